// ---- rtl/crx_pkg.sv ----
// Purpose: constants for the receive-side queue and status registers
// Assumes: AHB-Lite word registers, one clock, async active-high reset
// Notes:   Function list below
package crx_pkg;
    localparam logic [11:0] OFS_IDMSK   = 12'h090;
    localparam logic [11:0] OFS_PRIO    = 12'h094;
    localparam logic [11:0] OFS_NDLO    = 12'h098;
    localparam logic [11:0] OFS_NDHI    = 12'h09c;
    localparam logic [11:0] OFS_Q0CFG   = 12'h0a0;
    localparam logic [11:0] OFS_Q0STS   = 12'h0a4;
    localparam logic [11:0] OFS_Q0ACK   = 12'h0a8;
    localparam logic [11:0] OFS_RXBCFG  = 12'h0ac;
    localparam logic [11:0] OFS_Q1CFG   = 12'h0b0;
    localparam logic [11:0] OFS_Q1STS   = 12'h0b4;
    localparam logic [11:0] OFS_Q1ACK   = 12'h0b8;
    localparam logic [11:0] OFS_ESC     = 12'h0bc;
    localparam logic [28:0] MASK_RESET  = 29'h1fff_ffff;
    localparam logic [31:0] QCFG_MASK   = 32'hff7f_fffc;
    localparam logic [31:0] RXB_MASK    = 32'h0000_fffc;
    localparam logic [31:0] ESC_MASK    = 32'h0000_0777;
    localparam logic [6:0]  QMAX        = 7'h40;
    localparam int          MODE_BIT    = 31;
    localparam int          WM_HI       = 30;
    localparam int          SZ_HI       = 22;
    localparam int          LOST_BIT    = 25;
    localparam int          FULL_BIT    = 24;
    localparam logic [1:0]  STI_NONE    = 2'h0;
    localparam logic [1:0]  STI_LOST    = 2'h1;
    localparam logic [1:0]  STI_Q0      = 2'h2;
    localparam logic [1:0]  STI_Q1      = 2'h3;
    typedef enum logic [1:0] {
        DBG_IDLE = 2'b00,
        DBG_A    = 2'b01,
        DBG_AB   = 2'b10,
        DBG_ABC  = 2'b11
    } crx_dbg_t;
    function automatic logic [6:0] crx_eff_size(input logic [6:0] s);
        crx_eff_size = (s > QMAX) ? QMAX : s;
    endfunction
    function automatic logic [6:0] crx_elem_bytes(input logic [2:0] c);
        case (c)
            3'd0:    crx_elem_bytes = 7'd8;
            3'd1:    crx_elem_bytes = 7'd12;
            3'd2:    crx_elem_bytes = 7'd16;
            3'd3:    crx_elem_bytes = 7'd20;
            3'd4:    crx_elem_bytes = 7'd24;
            3'd5:    crx_elem_bytes = 7'd32;
            3'd6:    crx_elem_bytes = 7'd48;
            default: crx_elem_bytes = 7'd64;
        endcase
    endfunction
endpackage

// ---- rtl/crx_queue.sv ----
// Purpose: index bookkeeping of one receive queue
// Assumes: store requests and acks come as one-cycle pulses
// Notes:   element storage lives in message ram outside
`timescale 1ns/1ns
`default_nettype none
module crx_queue
    import crx_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [6:0] size_raw,
    input  wire logic [6:0] wmark,
    input  wire logic       ovw_mode,
    input  wire logic       store_req,
    input  wire logic       ack_wr,
    input  wire logic [5:0] ack_idx,
    input  wire logic       lost_clr,
    output logic            stored,
    output logic [5:0]      store_idx,
    output logic            lost_evt,
    output logic            wmark_hit,
    output logic            lost_q,
    output logic            full,
    output logic [5:0]      put_q,
    output logic [5:0]      get_q,
    output logic [6:0]      fill_q
);
    logic [6:0] size;
    logic [5:0] put_inc;
    logic [5:0] get_inc;
    logic [5:0] ack_nxt;
    logic [6:0] ack_fill;
    logic       drop;
    logic       over;

    assign size = crx_eff_size(size_raw);
    assign put_inc = (put_q == 6'(size - 7'd1)) ? 6'h0 : put_q + 6'd1;
    assign get_inc = (get_q == 6'(size - 7'd1)) ? 6'h0 : get_q + 6'd1;
    assign ack_nxt = (ack_idx == 6'(size - 7'd1)) ? 6'h0 : ack_idx + 6'd1;
    // fill from put and new get
    assign ack_fill = (put_q >= ack_nxt) ? 7'(put_q - ack_nxt)
                    : 7'(size - 7'(ack_nxt) + 7'(put_q));
    assign full = (size != 7'h0) && (fill_q == size);
    assign drop = store_req && ((size == 7'h0) || (full && !ovw_mode));
    assign over = store_req && full && ovw_mode;
    assign stored = store_req && !drop;
    assign store_idx = put_q;
    assign lost_evt = drop;
    assign wmark_hit = (wmark != 7'h0) && (wmark <= QMAX)
                    && (fill_q >= wmark);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            put_q  <= 6'h0;
            get_q  <= 6'h0;
            fill_q <= 7'h0;
        end else if (stored) begin
            put_q <= put_inc;
            if (over) begin
                get_q <= get_inc;
            end else begin
                fill_q <= fill_q + 7'd1;
            end
        end else if (ack_wr && size != 7'h0) begin
            get_q  <= ack_nxt;
            fill_q <= (ack_nxt == put_q && full) ? 7'h0 : ack_fill;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lost_q <= 1'b0;
        end else if (drop) begin
            lost_q <= 1'b1;
        end else if (lost_clr) begin
            lost_q <= 1'b0;
        end
    end

    property p_fill_bound;
        @(posedge clk) disable iff (rst) fill_q <= QMAX;
    endproperty
    a_fill_bound: assert property (p_fill_bound)
        else $error("fill level above 64");
    property p_drop_lost;
        @(posedge clk) disable iff (rst) drop |=> lost_q;
    endproperty
    a_drop_lost: assert property (p_drop_lost)
        else $error("dropped message did not set lost");
    property p_over_keep;
        @(posedge clk) disable iff (rst)
            over && !lost_q |=> !lost_q && $stable(fill_q);
    endproperty
    a_over_keep: assert property (p_over_keep)
        else $error("overwrite changed lost or fill");
    property p_full_size;
        @(posedge clk) disable iff (rst) full |-> fill_q == size;
    endproperty
    a_full_size: assert property (p_full_size)
        else $error("full without fill equal size");
endmodule
`default_nettype wire

// ---- rtl/crx_regs.sv ----
// Purpose: receive-side queue, priority and new-data register block
// Assumes: ahb-lite slave, zero wait states, okay response only
// Notes:   filter engine and message ram writer drive the event ports
`timescale 1ns/1ns
`default_nettype none
module crx_regs
    import crx_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [28:0] rx_ext_id,
    output logic [28:0]      masked_ext_id,
    input  wire logic        prio_match,
    input  wire logic        prio_ext_list,
    input  wire logic [6:0]  prio_filter_idx,
    input  wire logic [1:0]  prio_target,
    input  wire logic        q0_store_req,
    input  wire logic        q1_store_req,
    input  wire logic        rxbuf_write,
    input  wire logic [5:0]  rxbuf_idx,
    input  wire logic        debug_msg_rx,
    input  wire logic        lost_clr0,
    input  wire logic        lost_clr1,
    input  wire logic [6:0]  rx_data_bytes,
    output logic [6:0]       q0_store_bytes,
    output logic [6:0]       q1_store_bytes,
    output logic [6:0]       rxbuf_store_bytes,
    output logic [15:0]      q0_base_addr,
    output logic [15:0]      q1_base_addr,
    output logic [15:0]      rxbuf_base_addr,
    output logic             q0_stored,
    output logic             q1_stored,
    output logic [5:0]       q0_store_idx,
    output logic [5:0]       q1_store_idx,
    output logic             q0_lost_evt,
    output logic             q1_lost_evt,
    output logic             q0_wmark,
    output logic             q1_wmark,
    output logic             dma_req
);
    ////////////////////////////////////////////////////////////////////
    logic [28:0] ext_id_mask_q;
    logic [31:0] prio_q;
    logic [63:0] new_data_flag_q;
    logic [31:0] q0cfg_q;
    logic [31:0] q1cfg_q;
    logic [31:0] rxbcfg_q;
    logic [31:0] esc_q;
    logic [5:0]  ack0_q;
    logic [5:0]  ack1_q;
    crx_dbg_t    debug_msg_state_q;
    logic        wr_pend_q;
    logic [11:0] wr_addr_q;
    logic        addr_ok;
    logic        wr_en;
    logic [1:0]  lost;
    logic [1:0]  fullb;
    logic [5:0]  put0;
    logic [5:0]  put1;
    logic [5:0]  get0;
    logic [5:0]  get1;
    logic [6:0]  fill0;
    logic [6:0]  fill1;
    logic        ack0_wr;
    logic        ack1_wr;

    function automatic logic wr_hit(input logic [11:0] a,
                                    input logic [11:0] ofs);
        wr_hit = (a == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // bus slave: writes land at the data phase, reads are registered
    assign addr_ok = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_en = wr_pend_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h0;
        end else if (hready) begin
            wr_pend_q <= addr_ok && hwrite;
            wr_addr_q <= haddr[11:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            case ({haddr[11:2], 2'b00})
                OFS_IDMSK:  hrdata <= {3'h0, ext_id_mask_q};
                OFS_PRIO:   hrdata <= prio_q;
                OFS_NDLO:   hrdata <= new_data_flag_q[31:0];
                OFS_NDHI:   hrdata <= new_data_flag_q[63:32];
                OFS_Q0CFG:  hrdata <= q0cfg_q;
                OFS_Q0STS:  hrdata <= {6'h0, lost[0], fullb[0], 2'h0,
                                       put0, 2'h0, get0, 1'b0, fill0};
                OFS_Q0ACK:  hrdata <= {26'h0, ack0_q};
                OFS_RXBCFG: hrdata <= rxbcfg_q;
                OFS_Q1CFG:  hrdata <= q1cfg_q;
                OFS_Q1STS:  hrdata <= {debug_msg_state_q, 4'h0, lost[1],
                                       fullb[1], 2'h0, put1, 2'h0, get1,
                                       1'b0, fill1};
                OFS_Q1ACK:  hrdata <= {26'h0, ack1_q};
                OFS_ESC:    hrdata <= esc_q;
                default:    hrdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // extended id mask
    assign masked_ext_id = rx_ext_id & ext_id_mask_q;

    // configuration registers; reserved bits forced to zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_id_mask_q <= MASK_RESET;
            q0cfg_q       <= 32'h0000_0000;
            q1cfg_q       <= 32'h0000_0000;
            rxbcfg_q      <= 32'h0000_0000;
            esc_q         <= 32'h0000_0000;
        end else if (wr_en) begin
            if (wr_hit(wr_addr_q, OFS_IDMSK)) begin
                ext_id_mask_q <= hwdata[28:0];
            end
            if (wr_hit(wr_addr_q, OFS_Q0CFG)) begin
                q0cfg_q <= hwdata & QCFG_MASK;
            end
            if (wr_hit(wr_addr_q, OFS_Q1CFG)) begin
                q1cfg_q <= hwdata & QCFG_MASK;
            end
            if (wr_hit(wr_addr_q, OFS_RXBCFG)) begin
                rxbcfg_q <= hwdata & RXB_MASK;
            end
            if (wr_hit(wr_addr_q, OFS_ESC)) begin
                esc_q <= hwdata & ESC_MASK;
            end
        end
    end

    assign q0_base_addr    = {q0cfg_q[15:2], 2'b00};
    assign q1_base_addr    = {q1cfg_q[15:2], 2'b00};
    assign rxbuf_base_addr = {rxbcfg_q[15:2], 2'b00};

    assign q0_store_bytes = (rx_data_bytes > crx_elem_bytes(esc_q[2:0]))
                          ? crx_elem_bytes(esc_q[2:0]) : rx_data_bytes;
    assign q1_store_bytes = (rx_data_bytes > crx_elem_bytes(esc_q[6:4]))
                          ? crx_elem_bytes(esc_q[6:4]) : rx_data_bytes;
    assign rxbuf_store_bytes =
        (rx_data_bytes > crx_elem_bytes(esc_q[10:8]))
        ? crx_elem_bytes(esc_q[10:8]) : rx_data_bytes;

    ////////////////////////////////////////////////////////////////////
    // ack write steers get index
    assign ack0_wr = wr_en && wr_hit(wr_addr_q, OFS_Q0ACK);
    assign ack1_wr = wr_en && wr_hit(wr_addr_q, OFS_Q1ACK);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack0_q <= 6'h0;
            ack1_q <= 6'h0;
        end else begin
            if (ack0_wr) begin
                ack0_q <= hwdata[5:0];
            end
            if (ack1_wr) begin
                ack1_q <= hwdata[5:0];
            end
        end
    end

    crx_queue u_q0 (
        .clk       (clk),
        .rst       (rst),
        .size_raw  (q0cfg_q[SZ_HI:16]),
        .wmark     (q0cfg_q[WM_HI:24]),
        .ovw_mode  (q0cfg_q[MODE_BIT]),
        .store_req (q0_store_req),
        .ack_wr    (ack0_wr),
        .ack_idx   (hwdata[5:0]),
        .lost_clr  (lost_clr0),
        .stored    (q0_stored),
        .store_idx (q0_store_idx),
        .lost_evt  (q0_lost_evt),
        .wmark_hit (q0_wmark),
        .lost_q    (lost[0]),
        .full      (fullb[0]),
        .put_q     (put0),
        .get_q     (get0),
        .fill_q    (fill0)
    );
    crx_queue u_q1 (
        .clk       (clk),
        .rst       (rst),
        .size_raw  (q1cfg_q[SZ_HI:16]),
        .wmark     (q1cfg_q[WM_HI:24]),
        .ovw_mode  (q1cfg_q[MODE_BIT]),
        .store_req (q1_store_req),
        .ack_wr    (ack1_wr),
        .ack_idx   (hwdata[5:0]),
        .lost_clr  (lost_clr1),
        .stored    (q1_stored),
        .store_idx (q1_store_idx),
        .lost_evt  (q1_lost_evt),
        .wmark_hit (q1_wmark),
        .lost_q    (lost[1]),
        .full      (fullb[1]),
        .put_q     (put1),
        .get_q     (get1),
        .fill_q    (fill1)
    );

    ////////////////////////////////////////////////////////////////////
    // priority capture, outcome from queue logic
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prio_q <= 32'h0000_0000;
        end else if (prio_match) begin
            prio_q[31:16] <= 16'h0;
            prio_q[15]    <= prio_ext_list;
            prio_q[14:8]  <= prio_filter_idx;
            if (prio_target == STI_Q0) begin
                prio_q[7:6] <= q0_stored ? STI_Q0 : STI_LOST;
                prio_q[5:0] <= q0_stored ? q0_store_idx : 6'h0;
            end else if (prio_target == STI_Q1) begin
                prio_q[7:6] <= q1_stored ? STI_Q1 : STI_LOST;
                prio_q[5:0] <= q1_stored ? q1_store_idx : 6'h0;
            end else begin
                prio_q[7:6] <= STI_NONE;
                prio_q[5:0] <= 6'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // new-data flags, set wins over clear
    genvar gi;
    generate
        for (gi = 0; gi < 64; gi++) begin : g_nf
            logic set_b;
            logic clr_b;
            assign set_b = rxbuf_write && (rxbuf_idx == 6'(gi));
            assign clr_b = wr_en && hwdata[gi % 32]
                && wr_hit(wr_addr_q, (gi < 32) ? OFS_NDLO : OFS_NDHI);
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    new_data_flag_q[gi] <= 1'b0;
                end else if (set_b) begin
                    new_data_flag_q[gi] <= 1'b1;
                end else if (clr_b) begin
                    new_data_flag_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // debug message sequence
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            debug_msg_state_q <= DBG_IDLE;
        end else begin
            case (debug_msg_state_q)
                DBG_IDLE: if (debug_msg_rx) debug_msg_state_q <= DBG_A;
                DBG_A:    if (debug_msg_rx) debug_msg_state_q <= DBG_AB;
                DBG_AB:   if (debug_msg_rx) debug_msg_state_q <= DBG_ABC;
                // host restarts the sequence by reading status 1
                DBG_ABC:  if (addr_ok && !hwrite
                              && haddr[11:0] == OFS_Q1STS)
                              debug_msg_state_q <= DBG_IDLE;
                default:  debug_msg_state_q <= DBG_IDLE;
            endcase
        end
    end
    assign dma_req = (debug_msg_state_q == DBG_ABC);

    ////////////////////////////////////////////////////////////////////
    sequence s_prio_q0;
        prio_match && prio_target == STI_Q0 && q0_stored;
    endsequence
    property p_prio_q0;
        @(posedge clk) disable iff (rst)
            s_prio_q0 |=> prio_q[7:6] == STI_Q0
                && prio_q[5:0] == $past(q0_store_idx);
    endproperty
    a_prio_q0: assert property (p_prio_q0)
        else $error("priority status missed queue 0 store");
    property p_prio_list;
        @(posedge clk) disable iff (rst)
            prio_match |=> prio_q[15] == $past(prio_ext_list)
                && prio_q[14:8] == $past(prio_filter_idx);
    endproperty
    a_prio_list: assert property (p_prio_list)
        else $error("priority list or index not captured");
    property p_nf_set;
        @(posedge clk) disable iff (rst)
            rxbuf_write |=> new_data_flag_q[$past(rxbuf_idx)];
    endproperty
    a_nf_set: assert property (p_nf_set)
        else $error("new-data flag not set");
    property p_mask;
        @(posedge clk) disable iff (rst)
            masked_ext_id == (rx_ext_id & ext_id_mask_q);
    endproperty
    a_mask: assert property (p_mask)
        else $error("masked id wrong");
    property p_ack_get;
        @(posedge clk) disable iff (rst)
            ack0_wr && !q0_store_req && q0cfg_q[SZ_HI:16] != 7'h0
                && q0cfg_q[SZ_HI:16] <= QMAX
                |=> 7'(get0) == ((7'($past(hwdata[5:0])) + 7'd1
                    == $past(q0cfg_q[SZ_HI:16]))
                    ? 7'h0 : 7'($past(hwdata[5:0])) + 7'd1);
    endproperty
    a_ack_get: assert property (p_ack_get)
        else $error("ack did not move get index");
    property p_dma;
        @(posedge clk) disable iff (rst)
            debug_msg_state_q == DBG_AB && debug_msg_rx |=> dma_req;
    endproperty
    a_dma: assert property (p_dma)
        else $error("dma request not raised after c");
endmodule
`default_nettype wire

// ---- sim/crx_frame_src.sv ----
// Purpose: frame source model that raises receive events
// Assumes: one-cycle pulses, changed just after a rising edge
// Notes:   idle qualifiers invert, so a stale value never matches
`timescale 1ns/1ns
`default_nettype none
module crx_frame_src (
    input  wire logic clk,
    output logic       q0_store_req,
    output logic       q1_store_req,
    output logic       prio_match,
    output logic       prio_ext_list,
    output logic [6:0] prio_filter_idx,
    output logic [1:0] prio_target,
    output logic       rxbuf_write,
    output logic [5:0] rxbuf_idx,
    output logic       debug_msg_rx
);
    initial begin
        q0_store_req = 1'b0;
        q1_store_req = 1'b0;
        prio_match = 1'b0;
        prio_ext_list = 1'b0;
        prio_filter_idx = 7'h00;
        prio_target = 2'h0;
        rxbuf_write = 1'b0;
        rxbuf_idx = 6'h00;
        debug_msg_rx = 1'b0;
    end
    task automatic frame(input logic a0, input logic a1, input logic pm,
                         input logic ext, input logic [6:0] fi,
                         input logic [1:0] tg);
        @(posedge clk);
        q0_store_req <= a0;
        q1_store_req <= a1;
        prio_match <= pm;
        prio_ext_list <= ext;
        prio_filter_idx <= fi;
        prio_target <= tg;
        @(posedge clk);
        q0_store_req <= 1'b0;
        q1_store_req <= 1'b0;
        prio_match <= 1'b0;
        prio_ext_list <= ~ext;
        prio_filter_idx <= ~fi;
        prio_target <= ~tg;
    endtask
    task automatic side(input logic bw, input logic dbg,
                        input logic [5:0] idx);
        @(posedge clk);
        rxbuf_write <= bw;
        rxbuf_idx <= idx;
        debug_msg_rx <= dbg;
        @(posedge clk);
        rxbuf_write <= 1'b0;
        debug_msg_rx <= 1'b0;
        rxbuf_idx <= ~idx;
    endtask
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// Purpose: self-checking bench for the receive register block
// Assumes: zero-wait ahb-lite slave, hsize fixed to word
// Notes:   comb outputs are sampled at the falling edge
`timescale 1ns/1ns
`default_nettype none
module testbench
    import crx_pkg::*;
;
    logic        clk, rst, hsel, hwrite, lost_clr0, lost_clr1;
    logic        q0r, q1r, pm, pe, bw, dbg, hreadyout, q0_wmark, dma_req;
    logic        hresp, q0_stored, q0_lost_evt, q1_lost_evt;
    logic [1:0]  htrans, pt;
    logic [2:0]  hsize;
    logic [5:0]  bi;
    logic [6:0]  pf, rx_data_bytes, q0_store_bytes;
    logic [6:0]  q1_store_bytes, rxbuf_store_bytes;
    logic [15:0] q0_base_addr, q1_base_addr, rxbuf_base_addr;
    logic [28:0] rx_ext_id, masked_ext_id;
    logic [31:0] haddr, hwdata, hrdata, rd;
    wire logic   hready;
    int          err_count, checks, store_n, lost_n;
    logic [6:0]  sz [8] = '{7'd8, 7'd12, 7'd16, 7'd20,
                            7'd24, 7'd32, 7'd48, 7'd64};
    assign hready = hreadyout;
    crx_frame_src u_crx_frame_src (.clk(clk), .q0_store_req(q0r),
        .q1_store_req(q1r), .prio_match(pm), .prio_ext_list(pe),
        .prio_filter_idx(pf), .prio_target(pt), .rxbuf_write(bw),
        .rxbuf_idx(bi), .debug_msg_rx(dbg));
    crx_regs u_crx_regs (.clk(clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rx_ext_id(rx_ext_id),
        .masked_ext_id(masked_ext_id), .prio_match(pm),
        .prio_ext_list(pe), .prio_filter_idx(pf), .prio_target(pt),
        .q0_store_req(q0r), .q1_store_req(q1r), .rxbuf_write(bw),
        .rxbuf_idx(bi), .debug_msg_rx(dbg), .lost_clr0(lost_clr0),
        .lost_clr1(lost_clr1), .rx_data_bytes(rx_data_bytes),
        .q0_store_bytes(q0_store_bytes),
        .q1_store_bytes(q1_store_bytes),
        .rxbuf_store_bytes(rxbuf_store_bytes),
        .q0_base_addr(q0_base_addr), .q1_base_addr(q1_base_addr),
        .rxbuf_base_addr(rxbuf_base_addr), .q0_stored(q0_stored),
        .q1_stored(), .q0_store_idx(), .q1_store_idx(),
        .q0_lost_evt(q0_lost_evt), .q1_lost_evt(q1_lost_evt),
        .q0_wmark(q0_wmark),
        .q1_wmark(), .dma_req(dma_req));
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // count one-cycle queue 0 store pulses and loss pulses of both queues while they stand
    always @(negedge clk) begin
        store_n += int'(q0_stored === 1'b1);
        lost_n += int'(q0_lost_evt === 1'b1) + int'(q1_lost_evt === 1'b1);
    end
    task automatic summarize;
        if (err_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // bounded wait for hready at a rising edge
    task automatic wt;
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50) begin
                err_count++;
                $display("mismatch %0t bus timeout", $time);
                summarize();
            end
            @(posedge clk);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {20'h0_0000, a};
        wt();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wt();
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
        chk(32'(hresp), 32'h0000_0000);
    endtask
    task automatic pulse_clr(input logic q1);
        @(posedge clk);
        lost_clr0 <= ~q1;
        lost_clr1 <= q1;
        @(posedge clk);
        lost_clr0 <= 1'b0;
        lost_clr1 <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_mask;
        rdchk(OFS_NDLO, 32'h0000_0000);
        rdchk(OFS_NDHI, 32'h0000_0000);
        @(posedge clk);
        rx_ext_id <= 29'h0abc_def1;
        @(negedge clk);
        chk(32'(masked_ext_id), 32'h0abc_def1);
        rdchk(OFS_IDMSK, 32'h1fff_ffff);
        bus(1'b1, OFS_IDMSK, 32'h0000_ffff);
        rdchk(OFS_IDMSK, 32'h0000_ffff);
        @(negedge clk);
        chk(32'(masked_ext_id), 32'h0000_def1);
        rdchk(12'h0c0, 32'h0000_0000);
    endtask
    task automatic t_queue;
        bus(1'b1, OFS_Q0CFG, 32'h0202_0100);
        rdchk(OFS_Q0CFG, 32'h0202_0100);
        chk(32'(q0_base_addr), 32'h0000_0100);
        u_crx_frame_src.frame(1'b1, 1'b0, 1'b0, 1'b0, 7'd0, 2'b00);
        @(negedge clk);
        chk(32'(q0_wmark), 32'h0000_0000);
        u_crx_frame_src.frame(1'b1, 1'b0, 1'b1, 1'b1, 7'd5, 2'b10);
        @(negedge clk);
        chk(32'(q0_wmark), 32'h0000_0001);
        rdchk(OFS_PRIO, 32'h0000_8581);
        u_crx_frame_src.frame(1'b1, 1'b0, 1'b1, 1'b0, 7'd3, 2'b10);
        bus(1'b0, OFS_PRIO, 32'h0000_0000);
        chk(rd & 32'hffff_ffc0, 32'h0000_0340);
        rdchk(OFS_Q0STS, 32'h0300_0002);
        pulse_clr(1'b0);
        // host acks the last element it read
        bus(1'b1, OFS_Q0ACK, 32'h0000_0001);
        rdchk(OFS_Q0STS, 32'h0000_0000);
        bus(1'b1, OFS_Q0CFG, 32'h8202_0100);
        repeat (3) u_crx_frame_src.frame(1'b1, 1'b0, 1'b0, 1'b0, 7'd0, 2'b00);
        rdchk(OFS_Q0STS, 32'h0101_0102);
        bus(1'b1, OFS_Q1CFG, 32'h0000_0040);
        u_crx_frame_src.frame(1'b0, 1'b1, 1'b0, 1'b0, 7'd0, 2'b00);
        rdchk(OFS_Q1STS, 32'h0200_0000);
        chk(32'(q1_base_addr), 32'h0000_0040);
        pulse_clr(1'b1);
        rdchk(OFS_Q1STS, 32'h0000_0000);
        chk(32'(store_n), 32'h0000_0005);
        chk(32'(lost_n), 32'h0000_0002);
    endtask
    task automatic t_flags;
        u_crx_frame_src.side(1'b1, 1'b0, 6'd3);
        u_crx_frame_src.side(1'b1, 1'b0, 6'd40);
        rdchk(OFS_NDLO, 32'h0000_0008);
        rdchk(OFS_NDHI, 32'h0000_0100);
        bus(1'b1, OFS_NDLO, 32'hffff_fff7);
        rdchk(OFS_NDLO, 32'h0000_0008);
        bus(1'b1, OFS_NDLO, 32'h0000_0008);
        rdchk(OFS_NDLO, 32'h0000_0000);
    endtask
    task automatic t_debug;
        bus(1'b1, OFS_RXBCFG, 32'h0000_0204);
        @(negedge clk);
        chk(32'(rxbuf_base_addr), 32'h0000_0204);
        repeat (2) u_crx_frame_src.side(1'b0, 1'b1, 6'd0);
        rdchk(OFS_Q1STS, 32'h8000_0000);
        u_crx_frame_src.side(1'b0, 1'b1, 6'd0);
        @(negedge clk);
        chk(32'(dma_req), 32'h0000_0001);
        rdchk(OFS_Q1STS, 32'hc000_0000);
        @(negedge clk);
        chk(32'(dma_req), 32'h0000_0000);
    endtask
    task automatic t_size;
        for (int c = 0; c < 8; c++) begin
            // codes above 8 bytes assume fd traffic
            bus(1'b1, OFS_ESC, {21'h0, 3'(c), 1'b0, 3'(c), 1'b0, 3'(c)});
            @(negedge clk);
            chk(32'(q0_store_bytes), 32'(sz[c]));
            chk(32'(q1_store_bytes), 32'(sz[c]));
            chk(32'(rxbuf_store_bytes), 32'(sz[c]));
        end
        @(posedge clk);
        rx_data_bytes <= 7'd12;
        @(negedge clk);
        chk(32'(q0_store_bytes), 32'h0000_000c);
        chk(32'(q1_store_bytes), 32'h0000_000c);
        chk(32'(rxbuf_store_bytes), 32'h0000_000c);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        err_count = 0;
        checks = 0;
        rst = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        hsize = 3'b010;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        rx_ext_id = 29'h0000_0000;
        lost_clr0 = 1'b0;
        lost_clr1 = 1'b0;
        rx_data_bytes = 7'd64;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_mask();
        t_queue();
        t_flags();
        t_debug();
        t_size();
        summarize();
    end
endmodule
`default_nettype wire
